// ===== ectb_pkg.sv
// package for the 16-bit event capture timer: register map, fields, modes
// assumes a classic wishbone slave with 32-bit data and byte addresses
package ectb_pkg;
	// word offsets (byte address = 4 * index)
	localparam logic [3:0] ECTB_CONTROL_WORD_A_IDX  = 4'h0;
	localparam logic [3:0] ECTB_CONTROL_WORD_B_IDX  = 4'h1;
	localparam logic [3:0] ECTB_EVCTL_IDX  = 4'h2;
	localparam logic [3:0] ECTB_FLAGS_IDX  = 4'h3;
	localparam logic [3:0] ECTB_STATUS_IDX = 4'h4;
	localparam logic [3:0] ECTB_COUNT_IDX  = 4'h5;
	localparam logic [3:0] ECTB_CCV_IDX    = 4'h6;
	// control word a fields
	localparam int ECTB_EN_BIT     = 0;
	localparam int ECTB_CLOCK_SOURCE_SELECT_LSB = 1;
	// control word b fields
	localparam int ECTB_MODE_LSB   = 0;
	localparam int ECTB_WOE_BIT    = 4;
	localparam int ECTB_INIT_BIT   = 5;
	// event control fields
	localparam int ECTB_EDGE_BIT   = 0;
	// flag fields
	localparam int ECTB_CAPTURE_FLAG_BIT   = 0;
	localparam int ECTB_OVF_BIT    = 1;
	// count limits
	localparam logic [15:0] ECTB_BOTTOM = 16'h0000;
	localparam logic [15:0] ECTB_MAX    = 16'hffff;
	localparam logic [15:0] ECTB_CCV_RST = 16'h0000;
	// clock source selections
	typedef enum logic [2:0] {
		ECTB_CK_DIV1  = 3'b000,
		ECTB_CK_DIV2  = 3'b001,
		ECTB_CK_COMP  = 3'b010,
		ECTB_CK_EVENT = 3'b111
	} ectb_clock_source_select_t;
	// operating modes
	typedef enum logic [2:0] {
		ECTB_M_PERIODIC = 3'b000,
		ECTB_M_TIMEOUT  = 3'b001,
		ECTB_M_CAPEVT   = 3'b010,
		ECTB_M_FREQ     = 3'b011,
		ECTB_M_PW       = 3'b100,
		ECTB_M_FPW      = 3'b101,
		ECTB_M_SHOT     = 3'b110,
		ECTB_M_PWM8     = 3'b111
	} ectb_mode_t;
endpackage : ectb_pkg

// ===== ectb_edge.sv
// edge detector for the event input and the companion timer tick
// assumes inputs synchronous to clk
`timescale 1ns/1ps
module ectb_edge (
	input  wire logic clk,      // system clock
	input  wire logic rst_n,    // async reset, active low
	input  wire logic sig,      // level to watch
	output logic      rise,     // one-cycle rising pulse
	output logic      fall      // one-cycle falling pulse
);
	logic sig_q; // previous sample

	// previous sample register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sig_q <= 1'b0;
		end else begin
			sig_q <= sig;
		end
	end

	assign rise = sig & ~sig_q;
	assign fall = ~sig & sig_q;
endmodule : ectb_edge

// ===== ectb_timer.sv
// 16-bit event capture timer with a wishbone register file
// assumes event and clock-source inputs are synchronous to clk
`timescale 1ns/1ps
module ectb_timer
	import ectb_pkg::*;
(
	input  wire logic        clk,          // system clock, 125 MHz
	input  wire logic        rst_n,        // async reset, active low
	input  wire logic        wb_cyc_i,     // bus cycle
	input  wire logic        wb_stb_i,     // strobe
	input  wire logic        wb_we_i,      // write enable
	input  wire logic [5:0]  wb_adr_i,     // byte address
	input  wire logic [3:0]  wb_sel_i,     // byte lanes
	input  wire logic [31:0] wb_dat_i,     // write data
	output logic [31:0]      wb_dat_o,     // read data
	output logic             wb_ack_o,     // acknowledge
	input  wire logic        comp_clk_tick,// companion timer tick
	input  wire logic        event_in,     // routed event channel
	input  wire logic        port_out,     // general-purpose port value
	output logic             wave_pin,     // waveform output pin
	output logic             capture_flag_event,   // capture event pulse
	output logic             ovf_event     // overflow event pulse
);
	////////////////////////////////////////////////////////////////////
	// registers and wires
	logic        en_q;           // counter enable
	logic [2:0]  clock_source_select_q;       // clock source select
	ectb_mode_t  mode_q;         // operating mode
	logic        woe_q;          // waveform output enable
	logic        init_q;         // waveform initial level
	logic        edge_q;         // event edge select
	logic [15:0] count_q;        // count value
	logic [15:0] ccv_q;          // compare/capture value
	logic        capture_flag_q;         // capture flag
	logic        ovf_q;          // overflow flag
	logic        run_q;          // counting in time-out mode
	logic        ack_q;          // bus answer
	logic        wave_q;         // waveform level
	logic        div_q;          // divide-by-two prescaler
	logic        tick;           // selected count tick
	logic        ev_rise, ev_fall, ev_start, ev_stop;
	logic        tog_rise;       // companion tick rising edge
	logic        req, wr, rd;    // bus decode
	logic [3:0]  idx;            // word index
	logic        frozen;         // time-out idle state
	logic        counting;       // counter may advance
	logic        at_max, at_cmp;
	logic        capture_flag_set, ovf_set;
	logic        cap_load;       // copy count into capture
	logic        restart;        // load bottom

	////////////////////////////////////////////////////////////////////
	// edge detection
	ectb_edge u_ev (
		.clk   (clk),
		.rst_n (rst_n),
		.sig   (event_in),
		.rise  (ev_rise),
		.fall  (ev_fall)
	);
	ectb_edge u_cmp (
		.clk   (clk),
		.rst_n (rst_n),
		.sig   (comp_clk_tick),
		.rise  (tog_rise),
		.fall  ()
	);

	// edge bit picks active polarity
	assign ev_start = edge_q ? ev_fall : ev_rise;
	assign ev_stop  = edge_q ? ev_rise : ev_fall;

	////////////////////////////////////////////////////////////////////
	// bus decode: one-cycle answer, every address answered
	assign req = wb_cyc_i & wb_stb_i & ~ack_q;
	assign idx = wb_adr_i[5:2];
	assign wr  = req & wb_we_i & wb_sel_i[0];
	assign rd  = req & ~wb_we_i;
	assign wb_ack_o = ack_q;

	// ack register, dropped the cycle after it is given
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req;
		end
	end

	////////////////////////////////////////////////////////////////////
	// prescaler divide-by-two
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			div_q <= 1'b0;
		end else begin
			div_q <= ~div_q;
		end
	end

	// tick selection from clock-source field
	always_comb begin
		unique case (clock_source_select_q)
		ECTB_CK_DIV1:  tick = 1'b1;
		ECTB_CK_DIV2:  tick = div_q;
		ECTB_CK_COMP:  tick = tog_rise;
		ECTB_CK_EVENT: tick = ev_rise;
		default:       tick = 1'b1;           // reserved codes
		endcase
	end

	////////////////////////////////////////////////////////////////////
	// mode-dependent control terms
	assign frozen   = (mode_q == ECTB_M_TIMEOUT) & ~run_q;
	assign counting = en_q & tick & ~frozen;
	assign at_max   = count_q == ECTB_MAX;
	assign at_cmp   = count_q == ccv_q;

	// capture on edge in capture-on-event and frequency modes only
	assign cap_load = en_q & ev_start &
		((mode_q == ECTB_M_CAPEVT) | (mode_q == ECTB_M_FREQ));
	// restarts to bottom
	assign restart = en_q & (
		((mode_q == ECTB_M_FREQ) & ev_start) |
		((mode_q == ECTB_M_TIMEOUT) & frozen & ev_start) |
		((mode_q == ECTB_M_PERIODIC) & counting & at_cmp));

	// flag set terms
	always_comb begin
		capture_flag_set = 1'b0;
		unique case (mode_q)
		ECTB_M_PERIODIC: capture_flag_set = counting & at_cmp;
		ECTB_M_TIMEOUT:  capture_flag_set = counting & at_cmp;
		ECTB_M_CAPEVT,
		ECTB_M_FREQ:     capture_flag_set = cap_load;
		default:         capture_flag_set = counting & at_cmp;
		endcase
	end
	// overflow when wrapping at maximum, any mode
	assign ovf_set = counting & at_max & ~restart;

	assign capture_flag_event = capture_flag_set;
	assign ovf_event  = ovf_set;

	////////////////////////////////////////////////////////////////////
	// control registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			en_q     <= 1'b0;
			clock_source_select_q <= 3'b000;
			mode_q   <= ECTB_M_PERIODIC;
			woe_q    <= 1'b0;
			init_q   <= 1'b0;
			edge_q   <= 1'b0;
		end else if (wr) begin
			unique case (idx)
			ECTB_CONTROL_WORD_A_IDX: begin
				en_q     <= wb_dat_i[ECTB_EN_BIT];
				clock_source_select_q <= wb_dat_i[ECTB_CLOCK_SOURCE_SELECT_LSB +: 3];
			end
			ECTB_CONTROL_WORD_B_IDX: begin
				mode_q <= ectb_mode_t'(wb_dat_i[ECTB_MODE_LSB +: 3]);
				woe_q  <= wb_dat_i[ECTB_WOE_BIT];
				init_q <= wb_dat_i[ECTB_INIT_BIT];
			end
			ECTB_EVCTL_IDX: begin
				edge_q <= wb_dat_i[ECTB_EDGE_BIT];
			end
			default: begin
				// other words hold their own state
			end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// time-out run state
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			run_q <= 1'b0;
		end else if (mode_q != ECTB_M_TIMEOUT || !en_q) begin
			run_q <= 1'b0;
		end else if (!run_q && ev_start) begin
			run_q <= 1'b1;
		end else if (run_q && ev_stop) begin
			run_q <= 1'b0;
		end else if (run_q && wr && idx == ECTB_STATUS_IDX) begin
			run_q <= wb_dat_i[0];     // only acts while running
		end
	end

	////////////////////////////////////////////////////////////////////
	// counter: software write wins over counting
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			count_q <= ECTB_BOTTOM;
		end else if (wr && idx == ECTB_COUNT_IDX) begin
			count_q <= wb_dat_i[15:0];
		end else if (restart) begin
			count_q <= ECTB_BOTTOM;
		end else if (counting) begin
			count_q <= count_q + 16'h0001;
		end
	end

	// compare/capture value
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ccv_q <= ECTB_CCV_RST;
		end else if (cap_load) begin
			ccv_q <= count_q;
		end else if (wr && idx == ECTB_CCV_IDX) begin
			ccv_q <= wb_dat_i[15:0];
		end
	end

	////////////////////////////////////////////////////////////////////
	// flags: hardware set beats software clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			capture_flag_q <= 1'b0;
		end else if (capture_flag_set) begin
			capture_flag_q <= 1'b1;
		end else if (wr && idx == ECTB_FLAGS_IDX &&
			wb_dat_i[ECTB_CAPTURE_FLAG_BIT]) begin
			capture_flag_q <= 1'b0;
		end else if (rd && idx == ECTB_CCV_IDX && wb_sel_i[0] &&
			(mode_q == ECTB_M_CAPEVT || mode_q == ECTB_M_FREQ)) begin
			capture_flag_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ovf_q <= 1'b0;
		end else if (ovf_set) begin
			ovf_q <= 1'b1;
		end else if (wr && idx == ECTB_FLAGS_IDX &&
			wb_dat_i[ECTB_OVF_BIT]) begin
			ovf_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////
	// read data, registered
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (rd) begin
			unique case (idx)
			ECTB_CONTROL_WORD_A_IDX:  wb_dat_o <= {28'h0, clock_source_select_q, en_q};
			ECTB_CONTROL_WORD_B_IDX:  wb_dat_o <= {26'h0, init_q, woe_q, 1'b0,
				mode_q};
			ECTB_EVCTL_IDX:  wb_dat_o <= {31'h0, edge_q};
			ECTB_FLAGS_IDX:  wb_dat_o <= {30'h0, ovf_q, capture_flag_q};
			ECTB_STATUS_IDX: wb_dat_o <= {31'h0, run_q};
			ECTB_COUNT_IDX:  wb_dat_o <= {16'h0, count_q};
			ECTB_CCV_IDX:    wb_dat_o <= {16'h0, ccv_q};
			default:         wb_dat_o <= 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////
	// waveform: toggles on each capture flag set (compare match, or capture in capture modes), starts at init level
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wave_q <= 1'b0;
		end else if (!en_q) begin
			wave_q <= init_q;
		end else if (capture_flag_set) begin
			wave_q <= ~wave_q;
		end
	end

	// pin mux: waveform overrides port value
	assign wave_pin = woe_q ? wave_q : port_out;

	////////////////////////////////////////////////////////////////////
	// checks
	sequence s_match;
		en_q && tick && mode_q == ECTB_M_PERIODIC && at_cmp &&
		!(wr && idx == ECTB_COUNT_IDX);
	endsequence

	periodic_restart_a: assert property (@(posedge clk) disable iff (!rst_n)
		s_match |=> count_q == ECTB_BOTTOM && capture_flag_q)
		else $error("periodic match did not restart");

	wrap_max_a: assert property (@(posedge clk) disable iff (!rst_n)
		counting && at_max && !restart && !wr |=> count_q == ECTB_BOTTOM)
		else $error("count did not wrap");
	hold_off_a: assert property (@(posedge clk) disable iff (!rst_n)
		!en_q && !wr |=> $stable(count_q))
		else $error("count moved while disabled");
	// built from the raw terms so a broken set term still shows up
	ovf_flag_a: assert property (@(posedge clk) disable iff (!rst_n)
		en_q && tick && !frozen && at_max && !restart |->
		ovf_event ##1 ovf_q)
		else $error("overflow event or flag missing");
	capture_copy_a: assert property (@(posedge clk) disable iff (!rst_n)
		cap_load |=> ccv_q == $past(count_q) && capture_flag_q)
		else $error("capture did not copy count");
	freq_restart_a: assert property (@(posedge clk) disable iff (!rst_n)
		cap_load && mode_q == ECTB_M_FREQ && !wr |=> count_q == ECTB_BOTTOM)
		else $error("frequency mode did not restart");
	frozen_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
		frozen && !ev_start && !wr |=> $stable(count_q))
		else $error("count moved while frozen");
	pin_mux_a: assert property (@(posedge clk) disable iff (!rst_n)
		woe_q |-> wave_pin == wave_q)
		else $error("waveform not on pin");
	reset_mode_a: assert property (@(posedge clk)
		!rst_n |=> mode_q == ECTB_M_PERIODIC)
		else $error("reset mode not periodic");
endmodule : ectb_timer

// ===== ectb_evsrc.sv
// partner model: routed event channel and companion timer tick source
// assumes levels synchronous to clk; bench keeps half_per at two or more
`timescale 1ns/1ps
module ectb_evsrc (
	input  wire logic       clk,       // system clock
	input  wire logic       rst_n,     // async reset, active low
	input  wire logic       ev_run,    // event square wave on
	input  wire logic [7:0] half_per,  // clocks per event level
	input  wire logic       ck_run,    // companion ticks on
	output logic            event_in,  // routed event level
	output logic            comp_tick  // companion tick level
);
	logic [7:0] ev_cnt_q; // clocks spent in this level
	logic [1:0] ck_cnt_q; // companion divider
	////////////////////////////////////////////////////////////////////
	// each level lasts half_per clocks so every edge is seen;
	// idle is low, so stopping while low leaves no stray edge; stopping while high gives one falling edge
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			event_in <= 1'b0;
			ev_cnt_q <= 8'h00;
		end else if (!ev_run) begin
			event_in <= 1'b0;
			ev_cnt_q <= 8'h00;
		end else if (ev_cnt_q + 8'h01 >= half_per) begin
			event_in <= ~event_in;
			ev_cnt_q <= 8'h00;
		end else begin
			ev_cnt_q <= ev_cnt_q + 8'h01;
		end
	end
	// companion clock: one clock high in four, like a slow timer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ck_cnt_q <= 2'h0;
		end else begin
			ck_cnt_q <= ck_run ? ck_cnt_q + 2'h1 : 2'h0;
		end
	end
	assign comp_tick = (ck_cnt_q == 2'h3);
endmodule : ectb_evsrc

// ===== event_capture_timer_16_tb_top.sv
// bench: drives the timer over wishbone and judges counts and flags
// assumes the event source model feeds event_in and comp_clk_tick
`timescale 1ns/1ps
module event_capture_timer_16_tb_top;
	import ectb_pkg::*;
	logic        clk;      // system clock
	logic        rst_n;    // async reset
	logic        cyc;      // cyc and strobe together
	logic        we;       // write
	logic [5:0]  adr;      // byte address
	logic [31:0] wdat;     // write data
	logic [3:0]  sel;      // byte lanes on the bus
	logic [3:0]  lanes;    // lanes for the next request
	logic [31:0] rdat;     // read data
	logic        ack;      // acknowledge
	logic        port_out; // port value
	logic        wave_pin; // pin level
	logic        capture_flag_ev;  // capture pulse
	logic        ovf_ev;   // overflow pulse
	logic        ev_run;   // event wave on
	logic        ck_run;   // companion ticks on
	logic [7:0]  half_per; // event half period
	logic        event_in; // event level
	logic        ctick;    // companion tick
	logic [31:0] r;        // last read
	logic [31:0] r2;       // earlier read
	int          failures;
	int          n_checks;
	////////////////////////////////////////////////////////////////////
	ectb_timer dut_u (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc),
		.wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.comp_clk_tick(ctick), .event_in(event_in),
		.port_out(port_out), .wave_pin(wave_pin),
		.capture_flag_event(capture_flag_ev), .ovf_event(ovf_ev));
	ectb_evsrc src_u (.clk(clk), .rst_n(rst_n), .ev_run(ev_run),
		.half_per(half_per), .ck_run(ck_run), .event_in(event_in),
		.comp_tick(ctick));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////
	task automatic chk(input logic ok, input string m);
		n_checks++;
		if (ok !== 1'b1) begin
			failures++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask : chk
	// one classic cycle; request held until ack is sampled high
	task automatic bus(input logic w, input logic [3:0] i,
		input logic [31:0] d);
		int k;
		@(posedge clk);
		cyc <= 1'b1;
		we <= w;
		sel <= lanes;
		adr <= {i, 2'b00};
		wdat <= d;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (ack !== 1'b1 && k < 40);
		r = rdat;
		cyc <= 1'b0;
		chk(k < 40, "no bus ack");
	endtask : bus
	// waits for a capture or overflow pulse, bounded
	task automatic wait_ev(input logic ovf);
		int k;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while ((ovf ? ovf_ev : capture_flag_ev) !== 1'b1 && k < 2000);
		chk(k < 2000, "event pulse missing");
	endtask : wait_ev
	// one event pulse: low, high for hp clocks, then low again
	task automatic pulse(input logic [7:0] hp);
		int k;
		half_per <= hp;
		ev_run <= 1'b1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (event_in !== 1'b1 && k < 99);
		do begin
			@(posedge clk);
			k++;
		end while (event_in !== 1'b0 && k < 199);
		ev_run <= 1'b0;
		chk(k < 199, "event pulse stuck");
	endtask : pulse
	////////////////////////////////////////////////////////////////////
	task automatic t_basic;
		bus(1'b0, ECTB_CONTROL_WORD_B_IDX, 32'h0);
		chk(r[2:0] === ECTB_M_PERIODIC, "reset mode");
		bus(1'b0, ECTB_COUNT_IDX, 32'h0);
		chk(r[15:0] === ECTB_BOTTOM, "reset count");
		bus(1'b0, 4'hf, 32'h0);
		chk(r === 32'h0, "unmapped read");
		for (int m = 7; m >= 0; m--) begin
			bus(1'b1, ECTB_CONTROL_WORD_B_IDX, 32'(m));
			bus(1'b0, ECTB_CONTROL_WORD_B_IDX, 32'h0);
			chk(r[2:0] === 3'(m), "mode readback");
		end
		bus(1'b1, ECTB_CCV_IDX, 32'h0000_ffff);
		bus(1'b1, ECTB_COUNT_IDX, 32'h0000_0010);
		repeat (8) @(posedge clk);
		bus(1'b0, ECTB_COUNT_IDX, 32'h0);
		chk(r[15:0] === 16'h0010, "count held");
		bus(1'b1, ECTB_CONTROL_WORD_A_IDX, 32'h1);
		bus(1'b0, ECTB_COUNT_IDX, 32'h0);
		r2 = r;
		bus(1'b0, ECTB_COUNT_IDX, 32'h0);
		chk(r[15:0] === r2[15:0] + 16'h0003, "step");
		$display("test basic done");
	endtask : t_basic
	task automatic t_periodic;
		int n;
		bus(1'b1, ECTB_CCV_IDX, 32'h0000_0004);
		bus(1'b1, ECTB_COUNT_IDX, 32'h0);
		wait_ev(1'b0);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (capture_flag_ev !== 1'b1 && n < 50);
		chk(n == 5, "periodic interval");
		bus(1'b0, ECTB_FLAGS_IDX, 32'h0);
		chk(r[ECTB_CAPTURE_FLAG_BIT] === 1'b1, "capture flag");
		// compare below count: runs on to max and wraps
		bus(1'b1, ECTB_COUNT_IDX, 32'h0000_fff8);
		bus(1'b1, ECTB_FLAGS_IDX, 32'h0000_0003);
		wait_ev(1'b1);
		bus(1'b1, ECTB_CONTROL_WORD_A_IDX, 32'h0);
		bus(1'b0, ECTB_FLAGS_IDX, 32'h0);
		chk(r[ECTB_OVF_BIT] === 1'b1, "overflow flag");
		bus(1'b0, ECTB_COUNT_IDX, 32'h0);
		chk(r[15:0] < 16'h0010, "wrap to zero");
		$display("test periodic done");
	endtask : t_periodic
	task automatic t_capture;
		bus(1'b1, ECTB_CONTROL_WORD_B_IDX, 32'h0000_0002);
		bus(1'b1, ECTB_EVCTL_IDX, 32'h0000_0001); // falling edge
		bus(1'b1, ECTB_COUNT_IDX, 32'h0);
		bus(1'b1, ECTB_FLAGS_IDX, 32'h0000_0003);
		bus(1'b1, ECTB_CONTROL_WORD_A_IDX, 32'h0000_000f);
		pulse(8'h04);
		bus(1'b0, ECTB_FLAGS_IDX, 32'h0);
		chk(r[ECTB_CAPTURE_FLAG_BIT] === 1'b1, "capture_flag set");
		// a read without the low lane must leave the flag alone
		lanes = 4'he;
		bus(1'b0, ECTB_CCV_IDX, 32'h0);
		lanes = 4'hf;
		bus(1'b0, ECTB_FLAGS_IDX, 32'h0);
		chk(r[ECTB_CAPTURE_FLAG_BIT] === 1'b1, "upper lane kept capture_flag");
		bus(1'b0, ECTB_CCV_IDX, 32'h0);
		chk(r[15:0] === 16'h0001, "captured count");
		bus(1'b0, ECTB_FLAGS_IDX, 32'h0);
		chk(r[ECTB_CAPTURE_FLAG_BIT] === 1'b0, "capture_flag cleared");
		// frequency: rising edges twelve clocks apart
		bus(1'b1, ECTB_CONTROL_WORD_B_IDX, 32'h0000_0003);
		bus(1'b1, ECTB_EVCTL_IDX, 32'h0);
		bus(1'b1, ECTB_CONTROL_WORD_A_IDX, 32'h0000_0001);
		half_per <= 8'h06;
		ev_run <= 1'b1;
		wait_ev(1'b0);
		wait_ev(1'b0);
		ev_run <= 1'b0;
		bus(1'b0, ECTB_CCV_IDX, 32'h0);
		chk(r[15:0] >= 16'h000b && r[15:0] <= 16'h000c, "period");
		$display("test capture done");
	endtask : t_capture
	task automatic t_timeout;
		bus(1'b1, ECTB_CONTROL_WORD_B_IDX, 32'h0000_0001);
		bus(1'b1, ECTB_CCV_IDX, 32'h0000_0100);
		bus(1'b1, ECTB_COUNT_IDX, 32'h0);
		bus(1'b1, ECTB_FLAGS_IDX, 32'h0000_0003);
		pulse(8'h0a);
		bus(1'b0, ECTB_COUNT_IDX, 32'h0);
		r2 = r;
		bus(1'b1, ECTB_STATUS_IDX, 32'h0000_0001); // ignored frozen
		bus(1'b0, ECTB_COUNT_IDX, 32'h0);
		chk(r[15:0] === r2[15:0], "frozen");
		chk(r[15:0] >= 16'h0009 && r[15:0] <= 16'h000b, "span");
		bus(1'b0, ECTB_FLAGS_IDX, 32'h0);
		chk(r[ECTB_CAPTURE_FLAG_BIT] === 1'b0, "no early capture_flag");
		bus(1'b1, ECTB_CCV_IDX, 32'h0000_0004);
		pulse(8'h0a);
		bus(1'b0, ECTB_FLAGS_IDX, 32'h0);
		chk(r[ECTB_CAPTURE_FLAG_BIT] === 1'b1, "timeout capture_flag");
		// falling start: the rise is a stop edge and must not start
		bus(1'b1, ECTB_EVCTL_IDX, 32'h0000_0001);
		pulse(8'h04);
		bus(1'b0, ECTB_STATUS_IDX, 32'h0);
		chk(r[0] === 1'b1, "falling edge starts");
		bus(1'b1, ECTB_STATUS_IDX, 32'h0);
		bus(1'b0, ECTB_STATUS_IDX, 32'h0);
		chk(r[0] === 1'b0, "run write while running");
		bus(1'b1, ECTB_CONTROL_WORD_A_IDX, 32'h0);
		$display("test timeout done");
	endtask : t_timeout
	task automatic t_pin_clock;
		port_out <= 1'b1;
		bus(1'b1, ECTB_CONTROL_WORD_B_IDX, 32'h0);
		chk(wave_pin === 1'b1, "port passes");
		port_out <= 1'b0;
		bus(1'b1, ECTB_CONTROL_WORD_B_IDX, 32'h0000_0030);
		repeat (2) @(posedge clk);
		chk(wave_pin === 1'b1, "wave overrides");
		// companion clock: one tick every four clocks
		bus(1'b1, ECTB_CONTROL_WORD_B_IDX, 32'h0);
		bus(1'b1, ECTB_CCV_IDX, 32'h0000_ffff);
		bus(1'b1, ECTB_COUNT_IDX, 32'h0);
		ck_run <= 1'b1;
		bus(1'b1, ECTB_CONTROL_WORD_A_IDX, 32'h0000_0005);
		repeat (40) @(posedge clk);
		bus(1'b1, ECTB_CONTROL_WORD_A_IDX, 32'h0);
		ck_run <= 1'b0;
		bus(1'b0, ECTB_COUNT_IDX, 32'h0);
		chk(r[15:0] >= 16'h0009 && r[15:0] <= 16'h000c, "ticks");
		$display("test pin and clock done");
	endtask : t_pin_clock
	// half-rate prescaler in capture mode, run into the maximum
	task automatic t_div_ovf;
		bus(1'b1, ECTB_CONTROL_WORD_B_IDX, 32'h0000_0002);
		bus(1'b1, ECTB_FLAGS_IDX, 32'h0000_0003);
		bus(1'b1, ECTB_COUNT_IDX, 32'h0000_fff0);
		bus(1'b1, ECTB_CONTROL_WORD_A_IDX, 32'h0000_0003);
		wait_ev(1'b1);
		bus(1'b0, ECTB_FLAGS_IDX, 32'h0);
		chk(r[ECTB_OVF_BIT] === 1'b1, "capture mode overflow");
		bus(1'b0, ECTB_COUNT_IDX, 32'h0);
		r2 = r;
		bus(1'b0, ECTB_COUNT_IDX, 32'h0);
		// reads are three clocks apart: one or two half-rate ticks
		chk(r[15:0] >= r2[15:0] + 16'h0001 &&
			r[15:0] <= r2[15:0] + 16'h0002, "half rate");
		bus(1'b1, ECTB_CONTROL_WORD_A_IDX, 32'h0);
		$display("test divide and overflow done");
	endtask : t_div_ovf
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : wrap_up
	////////////////////////////////////////////////////////////////////
	initial begin
		#400000;
		failures++;
		$display("[ERR] %0t watchdog expired", $time);
		wrap_up();
	end
	initial begin
		rst_n = 1'b0;
		cyc = 1'b0;
		we = 1'b0;
		adr = 6'h00;
		wdat = 32'h0;
		sel = 4'hf;
		lanes = 4'hf;
		port_out = 1'b0;
		ev_run = 1'b0;
		ck_run = 1'b0;
		half_per = 8'h04;
		failures = 0;
		n_checks = 0;
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		t_basic();
		t_periodic();
		t_capture();
		t_timeout();
		t_pin_clock();
		t_div_ovf();
		wrap_up();
	end
endmodule : event_capture_timer_16_tb_top
